// file: sleep_mask_defs.svh
// register offsets, reset values and fixed masking constants of the sleep-state mask bank
`ifndef SLEEP_MASK_DEFS_SVH
`define SLEEP_MASK_DEFS_SVH
`define OFS_SLEEP_SELECT 8'he4
`define OFS_S1_GENERAL_INPUT_MASK 8'he5
`define OFS_S1_FAN_MASK 8'he6
`define OFS_S3_GENERAL_INPUT_MASK 8'he7
`define RST_S1_GENERAL_INPUT_MASK 8'hff
`define RST_S1_FAN_MASK 4'hf
`define RST_S3_GENERAL_INPUT_MASK 8'hff
`define SLEEP_RSVD_VALUE 6'h01
`define FAN_RSVD_VALUE 4'h0
`define STATE_S0 2'h0
`define STATE_S1 2'h1
`define STATE_S3 2'h2
`define STATE_S45 2'h3
`define STD_S1_GENERAL_INPUT_MASK 8'h00
`define STD_S1_FAN_MASK 4'h0
`define STD_S3_GENERAL_INPUT_MASK 8'h00
`define STD_S3_FAN_MASK 4'h0
`define STD_S45_GPI_MASK 8'h00
`define STD_S45_FAN_MASK 4'h0
`define READ_UNMAPPED 8'h00
`define NO_MASK 8'h00
`define RST_READ_DATA 8'h00
`define RST_GPI_EVENTS 8'h00
`define RST_FAN_EVENTS 4'h0
`endif

// file: sleep_mask_pkg.sv
// shared types of the sleep-state mask bank
package sleep_mask_pkg;
  typedef logic [1:0] sleep_field_t;
  typedef logic [7:0] reg_byte_t;
  typedef logic [3:0] fan_vec_t;
endpackage : sleep_mask_pkg

// file: sleep_state_error_masking.sv
// sleep-state register bank that suppresses input and fan error events per sleep state
`timescale 1ns/100ps
`include "sleep_mask_defs.svh"
//////////////////////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// [RQ1] two-bit sleep state field at bits 1:0; state 00 masks no error events
// [RQ2] state 01 masks events by the S1 mask registers plus fixed S1 masking
// [RQ3] state 10 masks events by the S3 input mask register and the S3 fan mask pins plus fixed S3 masking
// [RQ4] state 11 masks events by the S4/5 masks plus fixed S4/5 masking
// [RQ5] external reset input forces the sleep state to 11 while it is asserted
// [RQ6] S1 input mask bit n suppresses input n events in S1; resets to ff
// [RQ7] S1 fan mask bits 3:0 suppress fans 1 to 4 in S1; bits 7:4 read-only
// [RQ8] S3 input mask bit n suppresses input n events in S3; resets to ff
// [RQ9] masked events are not reported; masks of unselected states have no effect
//////////////////////////////////////////////////////////////////////////////////////////////////
module sleep_state_error_masking (
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic EXT_RESET_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_RD_I,
  output logic [7:0] REG_RDATA_O,
  input wire logic [3:0] S3_FAN_MASK_I,
  input wire logic [7:0] S45_GPI_MASK_I,
  input wire logic [3:0] S45_FAN_MASK_I,
  input wire logic [7:0] GPI_ERR_I,
  input wire logic [3:0] FAN_ERR_I,
  output logic [7:0] GPI_ERR_O,
  output logic [3:0] FAN_ERR_O,
  output logic [1:0] SLEEP_STATE_O
);

  //////////////////////////////////////////////////////////////////////////////////////////////
  // state and next values
  sleep_mask_pkg::sleep_field_t sleep_r;
  sleep_mask_pkg::sleep_field_t sleep_nxt;
  sleep_mask_pkg::reg_byte_t s1_gpi_r;
  sleep_mask_pkg::reg_byte_t s1_gpi_nxt;
  sleep_mask_pkg::fan_vec_t s1_fan_r;
  sleep_mask_pkg::fan_vec_t s1_fan_nxt;
  sleep_mask_pkg::reg_byte_t s3_gpi_r;
  sleep_mask_pkg::reg_byte_t s3_gpi_nxt;
  sleep_mask_pkg::reg_byte_t rdata_r;
  sleep_mask_pkg::reg_byte_t rdata_nxt;
  sleep_mask_pkg::reg_byte_t gpi_err_r;
  sleep_mask_pkg::reg_byte_t gpi_err_nxt;
  sleep_mask_pkg::fan_vec_t fan_err_r;
  sleep_mask_pkg::fan_vec_t fan_err_nxt;
  sleep_mask_pkg::reg_byte_t gpi_mask_eff;
  sleep_mask_pkg::fan_vec_t fan_mask_eff;
  sleep_mask_pkg::reg_byte_t fan_mask_wide;

  // picks the mask of the selected state, shared by input and fan paths
  function automatic sleep_mask_pkg::reg_byte_t pick_mask(
    input sleep_mask_pkg::sleep_field_t st,
    input sleep_mask_pkg::reg_byte_t m1,
    input sleep_mask_pkg::reg_byte_t m3,
    input sleep_mask_pkg::reg_byte_t m45
  );
    sleep_mask_pkg::reg_byte_t m;
    case (st)
      `STATE_S0: m = `NO_MASK; // RQ1
      `STATE_S1: m = m1; // RQ2
      `STATE_S3: m = m3; // RQ3
      `STATE_S45: m = m45; // RQ4
      default: m = `NO_MASK;
    endcase
    return m;
  endfunction : pick_mask

  //////////////////////////////////////////////////////////////////////////////////////////////
  // register writes and external reset override
  always_comb
  begin
    sleep_nxt = sleep_r;
    s1_gpi_nxt = s1_gpi_r;
    s1_fan_nxt = s1_fan_r;
    s3_gpi_nxt = s3_gpi_r;
    if (REG_WR_I)
    begin
      case (REG_ADDR_I)
        `OFS_SLEEP_SELECT: sleep_nxt = REG_WDATA_I[1:0]; // RQ1
        `OFS_S1_GENERAL_INPUT_MASK: s1_gpi_nxt = REG_WDATA_I; // RQ6
        `OFS_S1_FAN_MASK: s1_fan_nxt = REG_WDATA_I[3:0]; // RQ7
        `OFS_S3_GENERAL_INPUT_MASK: s3_gpi_nxt = REG_WDATA_I; // RQ8
        default: ;
      endcase
    end
    if (EXT_RESET_I)
    begin
      sleep_nxt = `STATE_S45; // RQ5
    end
    if (RST_I)
    begin
      sleep_nxt = `STATE_S45;
      s1_gpi_nxt = `RST_S1_GENERAL_INPUT_MASK; // RQ6
      s1_fan_nxt = `RST_S1_FAN_MASK; // RQ7
      s3_gpi_nxt = `RST_S3_GENERAL_INPUT_MASK; // RQ8
    end
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    sleep_r <= sleep_nxt;
    s1_gpi_r <= s1_gpi_nxt;
    s1_fan_r <= s1_fan_nxt;
    s3_gpi_r <= s3_gpi_nxt;
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // read data, reserved bits constant, unmapped reads zero
  always_comb
  begin
    rdata_nxt = rdata_r;
    if (REG_RD_I)
    begin
      case (REG_ADDR_I)
        `OFS_SLEEP_SELECT: rdata_nxt = {`SLEEP_RSVD_VALUE, sleep_r};
        `OFS_S1_GENERAL_INPUT_MASK: rdata_nxt = s1_gpi_r;
        `OFS_S1_FAN_MASK: rdata_nxt = {`FAN_RSVD_VALUE, s1_fan_r}; // RQ7
        `OFS_S3_GENERAL_INPUT_MASK: rdata_nxt = s3_gpi_r;
        default: rdata_nxt = `READ_UNMAPPED;
      endcase
    end
    if (RST_I)
    begin
      rdata_nxt = `RST_READ_DATA;
    end
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    rdata_r <= rdata_nxt;
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // effective masks of the selected state, then registered masked events
  always_comb
  begin
    gpi_mask_eff = pick_mask(sleep_r, s1_gpi_r | `STD_S1_GENERAL_INPUT_MASK,
                             s3_gpi_r | `STD_S3_GENERAL_INPUT_MASK,
                             S45_GPI_MASK_I | `STD_S45_GPI_MASK); // RQ9
    // fan mask comes back byte wide; low nibble holds the four fans
    fan_mask_wide = pick_mask(sleep_r, {4'h0, s1_fan_r | `STD_S1_FAN_MASK},
                              {4'h0, S3_FAN_MASK_I | `STD_S3_FAN_MASK},
                              {4'h0, S45_FAN_MASK_I | `STD_S45_FAN_MASK}); // RQ9
    fan_mask_eff = fan_mask_wide[3:0]; // RQ9
    gpi_err_nxt = GPI_ERR_I & ~gpi_mask_eff; // RQ9
    fan_err_nxt = FAN_ERR_I & ~fan_mask_eff; // RQ9
    if (RST_I)
    begin
      gpi_err_nxt = `RST_GPI_EVENTS;
      fan_err_nxt = `RST_FAN_EVENTS;
    end
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    gpi_err_r <= gpi_err_nxt;
    fan_err_r <= fan_err_nxt;
  end

  // outputs straight from flip-flops
  assign REG_RDATA_O = rdata_r;
  assign GPI_ERR_O = gpi_err_r;
  assign FAN_ERR_O = fan_err_r;
  assign SLEEP_STATE_O = sleep_r;

  //////////////////////////////////////////////////////////////////////////////////////////////
  // checks
  a_s0_no_mask: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // RQ1
    (!$past(RST_I) && $past(sleep_r) == 2'h0)
    |-> (GPI_ERR_O == $past(GPI_ERR_I) && FAN_ERR_O == $past(FAN_ERR_I)))
    else $error("events masked in state 00");
  a_s1_masking: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // RQ2
    (!$past(RST_I) && $past(sleep_r) == 2'h1)
    |-> (FAN_ERR_O == ($past(FAN_ERR_I) & ~$past(s1_fan_r))))
    else $error("fan events wrongly masked in state 01");
  a_s3_masking: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // RQ3
    (!$past(RST_I) && $past(sleep_r) == 2'h2)
    |-> (FAN_ERR_O == ($past(FAN_ERR_I) & ~$past(S3_FAN_MASK_I))))
    else $error("fan events wrongly masked in state 10");
  a_s45_masking: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // RQ4
    (!$past(RST_I) && $past(sleep_r) == 2'h3)
    |-> (GPI_ERR_O == ($past(GPI_ERR_I) & ~$past(S45_GPI_MASK_I))))
    else $error("input events wrongly masked in state 11");
  a_ext_reset_force: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // RQ5
    EXT_RESET_I |=> (SLEEP_STATE_O == 2'h3) [*1])
    else $error("external reset did not force state 11");
  a_s1_input_mask: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // RQ6
    (!$past(RST_I) && $past(sleep_r) == 2'h1)
    |-> (GPI_ERR_O == ($past(GPI_ERR_I) & ~$past(s1_gpi_r))))
    else $error("input events wrongly masked in state 01");
  a_fan_rsvd_read: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // RQ7
    (REG_RD_I && REG_ADDR_I == 8'he6) |=> (REG_RDATA_O[7:4] == 4'h0))
    else $error("fan mask reserved bits not zero");
  a_s3_input_mask: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // RQ8
    (!$past(RST_I) && $past(sleep_r) == 2'h2)
    |-> (GPI_ERR_O == ($past(GPI_ERR_I) & ~$past(s3_gpi_r))))
    else $error("input events wrongly masked in state 10");
  a_mask_reset_vals: assert property (@(posedge SYS_CLK_I) // RQ6
    RST_I |=> (s1_gpi_r == 8'hff && s3_gpi_r == 8'hff && s1_fan_r == 4'hf
               && sleep_r == 2'h3))
    else $error("mask reset values wrong");
  a_mask_only_clears: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // RQ9
    ((GPI_ERR_O & ~$past(GPI_ERR_I)) == 8'h00
     && (FAN_ERR_O & ~$past(FAN_ERR_I)) == 4'h0))
    else $error("masking raised an event that was not present");
  // covers of the main scenarios
  c_enter_s1: cover property (@(posedge SYS_CLK_I) disable iff (RST_I)
    REG_WR_I && REG_ADDR_I == 8'he4 && REG_WDATA_I[1:0] == 2'h1 ##1 sleep_r == 2'h1);
  c_ext_reset: cover property (@(posedge SYS_CLK_I) disable iff (RST_I)
    sleep_r == 2'h0 ##1 EXT_RESET_I ##1 sleep_r == 2'h3);
  c_masked_event: cover property (@(posedge SYS_CLK_I) disable iff (RST_I)
    sleep_r == 2'h2 && GPI_ERR_I != 8'h00 ##1 GPI_ERR_O == 8'h00);
  c_s45_passes: cover property (@(posedge SYS_CLK_I) disable iff (RST_I)
    sleep_r == 2'h3 && (GPI_ERR_I & ~S45_GPI_MASK_I) != 8'h00 ##1 GPI_ERR_O != 8'h00);
  c_mid_reset: cover property (@(posedge SYS_CLK_I)
    !RST_I ##1 RST_I ##1 !RST_I);

endmodule : sleep_state_error_masking

// file: reg_host.sv
// register host model driving the decoded byte port of the mask bank
`timescale 1ns/100ps
module reg_host (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic [7:0] addr_o,
  output logic wr_o,
  output logic [7:0] wdata_o,
  output logic rd_o
);
  // idle bus at time zero
  initial
  begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////////////////////
  // one-cycle write strobe; idle address and data inverted so stale values never linger
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask : wr
  // one-cycle read strobe; data taken once the taking edge has landed
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    rd_o = 1'b1;
    @(posedge clk_i);
    #1;
    rd_o = 1'b0;
    addr_o = ~a;
    d = rdata_i;
  endtask : rd
endmodule : reg_host

// file: sleep_state_error_masking_test.sv
// self-checking bench of the sleep-state mask bank
`timescale 1ns/100ps
`include "sleep_mask_defs.svh"
`define TB_CHK(g, e) \
  begin tests_run++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module sleep_state_error_masking_test;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic ext_rst = 1'b0;
  logic [7:0] addr, wdata, rdata, gpi_in, gpi_out, rv;
  logic wr, rd;
  logic [3:0] fan_in, fan_out;
  logic [1:0] state;
  int n_errors = 0;
  int tests_run = 0;
  localparam logic [7:0] M1 = 8'h5a, M3 = 8'h0f, M45 = 8'haa;
  localparam logic [3:0] F1 = 4'h5, F3 = 4'h3, F45 = 4'h9;
  localparam logic [7:0] RST_TAB [5] = '{8'h07, 8'hff, 8'h0f, 8'hff, 8'h00};
  localparam logic [7:0] GM [4] = '{8'h00, M1 | `STD_S1_GENERAL_INPUT_MASK, M3 | `STD_S3_GENERAL_INPUT_MASK,
    M45 | `STD_S45_GPI_MASK};
  localparam logic [3:0] FM [4] = '{4'h0, F1 | `STD_S1_FAN_MASK, F3 | `STD_S3_FAN_MASK,
    F45 | `STD_S45_FAN_MASK};
  logic [3:0] s3_fan = F3;
  logic [3:0] s45_fan = F45;
  logic [7:0] s45_gpi = M45;
  //////////////////////////////////////////////////////////////////////////////////////////////
  // design and host model
  sleep_state_error_masking uut (.SYS_CLK_I(sys_clk), .RST_I(rst), .EXT_RESET_I(ext_rst),
    .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_WDATA_I(wdata), .REG_RD_I(rd), .REG_RDATA_O(rdata),
    .S3_FAN_MASK_I(s3_fan), .S45_GPI_MASK_I(s45_gpi), .S45_FAN_MASK_I(s45_fan),
    .GPI_ERR_I(gpi_in),
    .FAN_ERR_I(fan_in), .GPI_ERR_O(gpi_out), .FAN_ERR_O(fan_out), .SLEEP_STATE_O(state));
  reg_host host (.clk_i(sys_clk), .rdata_i(rdata), .addr_o(addr), .wr_o(wr), .wdata_o(wdata),
    .rd_o(rd));
  //////////////////////////////////////////////////////////////////////////////////////////////
  // 100 MHz clock
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end
  // verdict and end of run
  task automatic close_out();
    if (n_errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out
  // watchdog against a hang
  initial
  begin
    #100000;
    n_errors++;
    close_out();
  end
  //////////////////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    gpi_in = 8'hff;
    fan_in = 4'hf;
    repeat (2) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    `TB_CHK(state, `STATE_S45)
    // reset readback of all mapped offsets and one unmapped
    for (int i = 0; i < 5; i++)
    begin
      host.rd(8'he4 + 8'(i), rv);
      `TB_CHK(rv, RST_TAB[i])
    end
    // program masks; reserved fan bits must not stick
    host.wr(`OFS_S1_GENERAL_INPUT_MASK, M1);
    host.wr(`OFS_S1_FAN_MASK, {4'hf, F1});
    host.wr(`OFS_S3_GENERAL_INPUT_MASK, M3);
    host.wr(8'he8, 8'h00);
    host.rd(`OFS_S1_FAN_MASK, rv);
    `TB_CHK(rv, {4'h0, F1})
    host.rd(`OFS_S1_GENERAL_INPUT_MASK, rv);
    `TB_CHK(rv, M1)
    host.rd(`OFS_S3_GENERAL_INPUT_MASK, rv);
    `TB_CHK(rv, M3)
    // every sleep state: readback and masking of all inputs
    for (int s = 0; s < 4; s++)
    begin
      host.wr(`OFS_SLEEP_SELECT, {6'h3f, 2'(s)});
      host.rd(`OFS_SLEEP_SELECT, rv);
      `TB_CHK(rv, {6'h01, 2'(s)})
      `TB_CHK(gpi_out, gpi_in & ~GM[s])
      `TB_CHK(fan_out, fan_in & ~FM[s])
    end
    // external reset forces the deepest state over a write
    host.wr(`OFS_SLEEP_SELECT, 8'h01);
    ext_rst = 1'b1;
    host.wr(`OFS_SLEEP_SELECT, 8'h00);
    `TB_CHK(state, `STATE_S45)
    @(posedge sys_clk);
    #1;
    `TB_CHK(gpi_out, gpi_in & ~GM[3])
    // outside masks follow their pins; other states' masks stay without effect
    gpi_in = 8'h0c;
    fan_in = 4'ha;
    s45_gpi = 8'hf0;
    s45_fan = 4'h3;
    s3_fan = 4'hf;
    @(posedge sys_clk);
    #1;
    `TB_CHK(gpi_out, gpi_in & ~(s45_gpi | `STD_S45_GPI_MASK))
    `TB_CHK(fan_out, fan_in & ~(s45_fan | `STD_S45_FAN_MASK))
    // after release writes select the state again
    ext_rst = 1'b0;
    host.wr(`OFS_SLEEP_SELECT, 8'h02);
    `TB_CHK(state, `STATE_S3)
    @(posedge sys_clk);
    #1;
    `TB_CHK(gpi_out, gpi_in & ~(M3 | `STD_S3_GENERAL_INPUT_MASK))
    `TB_CHK(fan_out, fan_in & ~(s3_fan | `STD_S3_FAN_MASK))
    // mid-run reset brings back the deepest state and mask defaults
    rst = 1'b1;
    @(posedge sys_clk);
    #1;
    rst = 1'b0;
    `TB_CHK(state, `STATE_S45)
    host.rd(`OFS_S1_GENERAL_INPUT_MASK, rv);
    `TB_CHK(rv, `RST_S1_GENERAL_INPUT_MASK)
    `TB_CHK(gpi_out, gpi_in & ~(s45_gpi | `STD_S45_GPI_MASK))
    close_out();
  end
endmodule : sleep_state_error_masking_test
